/* src/pqrm_pkg.sv */
// Package: register map, command codes, status and result encodings
package pqrm_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] PQRM_REG_FEAT  = 4'h1;
    localparam logic [3:0] PQRM_REG_CNTL  = 4'h2;
    localparam logic [3:0] PQRM_REG_CNTH  = 4'h3;
    localparam logic [3:0] PQRM_REG_CYLL  = 4'h4;
    localparam logic [3:0] PQRM_REG_CYLH  = 4'h5;
    localparam logic [3:0] PQRM_REG_UNIT  = 4'h6;
    localparam logic [3:0] PQRM_REG_CMD   = 4'h7;
    localparam logic [3:0] PQRM_REG_FLAGS = 4'h7;
    localparam logic [3:0] PQRM_REG_FAULT = 4'h1;
    localparam logic [3:0] PQRM_REG_CFG   = 4'h8;
    localparam logic [3:0] PQRM_REG_XFER  = 4'h9;
    // Command codes
    localparam logic [7:0] PQRM_CMD_PWRQ  = 8'hE5;
    localparam logic [7:0] PQRM_CMD_SRST  = 8'h08;
    localparam logic [7:0] PQRM_CMD_FWDL  = 8'h92;
    // Download subcommands
    localparam logic [7:0] PQRM_SUB_TEMP  = 8'h01;
    localparam logic [7:0] PQRM_SUB_SAVE  = 8'h07;
    // Power query result codes
    localparam logic [7:0] PQRM_PM_STBY   = 8'h00;
    localparam logic [7:0] PQRM_PM_IDLE   = 8'h80;
    localparam logic [7:0] PQRM_PM_ACTV   = 8'hFF;
    // Diagnostic codes
    localparam logic [7:0] PQRM_DIAG_PASS = 8'h01;
    localparam logic [7:0] PQRM_DIAG_D1F  = 8'h81;
    // Flag and field bit positions
    localparam int PQRM_BIT_BUSY  = 7;
    localparam int PQRM_BIT_RDY   = 6;
    localparam int PQRM_BIT_FLT   = 5;
    localparam int PQRM_BIT_XREQ  = 3;
    localparam int PQRM_BIT_ERR   = 0;
    localparam int PQRM_BIT_ABORTED_FLAG  = 2;
    localparam int PQRM_BIT_SEL   = 4;
    // Config register bit positions
    localparam int PQRM_CFG_PM    = 0;
    localparam int PQRM_CFG_PKT   = 1;
    localparam int PQRM_CFG_FWDL  = 2;
    localparam int PQRM_CFG_FT    = 3;
    localparam int PQRM_CFG_FS    = 4;
    localparam int PQRM_CFG_REJ   = 5;
    localparam int PQRM_CFG_D1F   = 6;
    localparam int PQRM_CFG_FLT   = 7;
    // Index of the last word in one 512-byte sector (16-bit data port)
    localparam logic [7:0] PQRM_WORDS_LAST = 8'hFF;
    localparam logic [7:0] PQRM_ZERO8 = 8'h00;

    typedef enum logic [1:0] {
        PQRM_PM_MODE_STANDBY = 2'b00,
        PQRM_PM_MODE_IDLE    = 2'b01,
        PQRM_PM_MODE_ACTIVE  = 2'b10
    } pqrm_pm_t;

    typedef enum logic [1:0] {
        PQRM_ST_IDLE = 2'b00,
        PQRM_ST_EXEC = 2'b01,
        PQRM_ST_DATA = 2'b10
    } pqrm_state_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pqrm_req_t;

    // Data-out word stream from the host
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } pqrm_word_t;
endpackage

/* src/pqrm_cmd.sv */
// Command interpreter: power query, soft reset, firmware download
// How it works
// RULE_01 - E5h reports power mode, nothing else
// RULE_02 - Power query has no data phase
// RULE_03 - Result 00h standby, 80h idle, FFh active
// RULE_04 - Good completion: ready set, others clear
// RULE_05 - No power management: abort power query
// RULE_06 - Error completion: ready, fault, error bits
// RULE_07 - Query needs ready, keeps power state
// RULE_08 - 08h resets only this unit
// RULE_09 - Soft reset accepted in any state
// RULE_10 - Reset loads diagnostic code and signature
// RULE_11 - Supported reset never errors; else abort
// RULE_12 - Soft reset only with packet feature
// RULE_13 - 92h starts host-to-device data download
// RULE_14 - Host zeroes head and cylinder registers
// RULE_15 - Count high from sector-number register
// RULE_16 - Whole sectors; zero count means none
// RULE_17 - Subcommand 01h temporary, 07h saved
// RULE_18 - Abort bad download or subcommand
// RULE_19 - Download only without packet, needs ready
// RULE_20 - Select bit shows the selected unit
// RULE_21 - Abort allowed when action impossible
// RULE_22 - Power management implies power query
// RULE_23 - Diagnostic 01h pass, 81h other failed
// RULE_24 - Ignore n/a bits; unknown command aborts
`timescale 1ns/1ps
`default_nettype none
module pqrm_cmd
    import pqrm_pkg::*;
#(
    // Signature bytes: arbitrary neutral values
    parameter logic [7:0] SIG_CNT = 8'h01,
    parameter logic [7:0] SIG_SEC = 8'h01,
    parameter logic [7:0] SIG_CYL = 8'h00,
    parameter logic [7:0] SIG_CYH = 8'h00
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              srst,
    // Register port
    input  wire pqrm_pkg::pqrm_req_t req,
    output logic [7:0]             rdata,
    // Download data stream
    input  wire pqrm_pkg::pqrm_word_t dl_word,
    output logic                   dl_ready,
    // Power state from the power manager
    input  wire pqrm_pkg::pqrm_pm_t pm_mode,
    // End-of-download pulse and subcommand out to the firmware store
    output logic                   dl_done,
    output logic [7:0]             dl_sub
);
    import pqrm_pkg::*;

    pqrm_state_t state;
    logic [7:0]  feat, cnt_l, cnt_h, cyl_l, cyl_h, unit, fault, cfg;
    logic        busy, rdy, flt, xreq, err_f;
    logic [15:0] sect_left;
    logic [7:0]  word_cnt;
    logic [7:0]  cmd_q;

    wire wr_cmd  = req.wr && req.addr == PQRM_REG_CMD;
    wire is_srst = req.wdata == PQRM_CMD_SRST;
    // RULE_09 Reset accepted while busy
    wire take_cmd = wr_cmd && (!busy || is_srst);
    wire wr_blk  = req.wr && !busy;
    // RULE_22 Power management enables the query
    wire pm_ok   = cfg[PQRM_CFG_PM];
    wire pkt     = cfg[PQRM_CFG_PKT];
    // RULE_17 Subcommand decode
    wire sub_ok  = (feat == PQRM_SUB_TEMP && cfg[PQRM_CFG_FT])
                || (feat == PQRM_SUB_SAVE && cfg[PQRM_CFG_FS]);
    // RULE_15 Sixteen-bit count
    wire [15:0] dl_count = {cnt_h, cnt_l};
    // RULE_03 Result code select
    wire [7:0] pm_code = (pm_mode == PQRM_PM_MODE_STANDBY) ? PQRM_PM_STBY :
                         (pm_mode == PQRM_PM_MODE_IDLE)    ? PQRM_PM_IDLE : PQRM_PM_ACTV;
    // RULE_23 Diagnostic code
    wire [7:0] diag = cfg[PQRM_CFG_D1F] ? PQRM_DIAG_D1F : PQRM_DIAG_PASS;
    wire [7:0] flags = {busy, rdy, flt, 1'b0, xreq, 2'b00, err_f};
    wire word_take = dl_word.valid && state == PQRM_ST_DATA;
    wire last_word = word_take && word_cnt == PQRM_WORDS_LAST;
    wire last_sect = sect_left == 16'h0001;

    assign dl_ready = state == PQRM_ST_DATA;
    assign dl_sub   = feat;

    // Read data one cycle after the strobe
    wire [7:0] rd_mux =
        (req.addr == PQRM_REG_FAULT) ? fault :
        (req.addr == PQRM_REG_CNTL)  ? cnt_l :
        (req.addr == PQRM_REG_CNTH)  ? cnt_h :
        (req.addr == PQRM_REG_CYLL)  ? cyl_l :
        (req.addr == PQRM_REG_CYLH)  ? cyl_h :
        (req.addr == PQRM_REG_UNIT)  ? unit  :
        (req.addr == PQRM_REG_FLAGS) ? flags :
        (req.addr == PQRM_REG_CFG)   ? cfg   :
        (req.addr == PQRM_REG_XFER)  ? sect_left[7:0] : PQRM_ZERO8;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata <= PQRM_ZERO8;
        end else begin
            rdata <= req.rd ? rd_mux : PQRM_ZERO8;
        end
    end

    // Config register; host writes taken in any state, busy included
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg <= PQRM_ZERO8;
        end else if (req.wr && req.addr == PQRM_REG_CFG) begin
            cfg <= req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state     <= PQRM_ST_IDLE;
            feat      <= PQRM_ZERO8;
            cnt_l     <= PQRM_ZERO8;
            cnt_h     <= PQRM_ZERO8;
            cyl_l     <= PQRM_ZERO8;
            cyl_h     <= PQRM_ZERO8;
            unit      <= PQRM_ZERO8;
            fault     <= PQRM_ZERO8;
            busy      <= 1'b0;
            rdy       <= 1'b1;
            flt       <= 1'b0;
            xreq      <= 1'b0;
            err_f     <= 1'b0;
            cmd_q     <= PQRM_ZERO8;
            sect_left <= 16'h0000;
            word_cnt  <= PQRM_ZERO8;
            dl_done   <= 1'b0;
        end else begin
            dl_done <= 1'b0;
            if (wr_blk) begin
                case (req.addr)
                    PQRM_REG_FEAT: feat  <= req.wdata;
                    PQRM_REG_CNTL: cnt_l <= req.wdata;
                    PQRM_REG_CNTH: cnt_h <= req.wdata;
                    PQRM_REG_CYLL: cyl_l <= req.wdata;
                    PQRM_REG_CYLH: cyl_h <= req.wdata;
                    PQRM_REG_UNIT: unit  <= req.wdata;
                    default: ;
                endcase
            end
            case (state)
                PQRM_ST_IDLE: begin
                    if (take_cmd) begin
                        cmd_q <= req.wdata;
                        busy  <= 1'b1;
                        state <= PQRM_ST_EXEC;
                    end
                end
                PQRM_ST_EXEC: begin
                    state <= PQRM_ST_IDLE;
                    busy  <= 1'b0;
                    rdy   <= 1'b1;
                    xreq  <= 1'b0;
                    // RULE_20 Select bit kept, others cleared
                    unit  <= unit & (8'h01 << PQRM_BIT_SEL);
                    case (cmd_q)
                        PQRM_CMD_PWRQ: begin
                            // RULE_05 Abort without power management
                            if (!pm_ok || !rdy) begin
                                fault <= 8'h01 << PQRM_BIT_ABORTED_FLAG;
                                err_f <= 1'b1;
                                flt   <= cfg[PQRM_CFG_FLT];
                            end else begin
                                // RULE_01 Report mode only
                                // RULE_07 Power state untouched
                                cnt_l <= pm_code;
                                fault <= PQRM_ZERO8;
                                err_f <= 1'b0;
                                flt   <= 1'b0;
                            end
                        end
                        PQRM_CMD_SRST: begin
                            // RULE_12 Packet units only
                            if (pkt) begin
                                // RULE_10 Diagnostic and signature
                                // RULE_08 Local reset only
                                fault <= diag;
                                cnt_l <= SIG_CNT;
                                cnt_h <= SIG_SEC;
                                cyl_l <= SIG_CYL;
                                cyl_h <= SIG_CYH;
                                err_f <= 1'b0;
                                flt   <= 1'b0;
                            end else begin
                                // RULE_11 Unsupported reset aborts
                                fault <= 8'h01 << PQRM_BIT_ABORTED_FLAG;
                                err_f <= 1'b1;
                                flt   <= cfg[PQRM_CFG_FLT];
                            end
                        end
                        PQRM_CMD_FWDL: begin
                            // RULE_19 Non-packet units with ready
                            // RULE_18 Abort bad subcommand
                            if (pkt || !cfg[PQRM_CFG_FWDL] || !sub_ok || !rdy) begin
                                fault <= 8'h01 << PQRM_BIT_ABORTED_FLAG;
                                err_f <= 1'b1;
                                flt   <= cfg[PQRM_CFG_FLT];
                            end else if (dl_count == 16'h0000) begin
                                // RULE_16 Zero count completes at once
                                fault <= PQRM_ZERO8;
                                err_f <= 1'b0;
                                flt   <= 1'b0;
                            end else begin
                                // RULE_13 Data-out phase
                                sect_left <= dl_count;
                                word_cnt  <= PQRM_ZERO8;
                                busy      <= 1'b0;
                                xreq      <= 1'b1;
                                state     <= PQRM_ST_DATA;
                            end
                        end
                        default: begin
                            // RULE_24 Unknown command aborts
                            // RULE_21 Abort when impossible
                            fault <= 8'h01 << PQRM_BIT_ABORTED_FLAG;
                            err_f <= 1'b1;
                            flt   <= cfg[PQRM_CFG_FLT];
                        end
                    endcase
                    // RULE_09 Reset written while busy runs next
                    if (take_cmd) begin
                        cmd_q <= req.wdata;
                        busy  <= 1'b1;
                        xreq  <= 1'b0;
                        state <= PQRM_ST_EXEC;
                    end
                end
                PQRM_ST_DATA: begin
                    if (take_cmd) begin
                        // Any command written, soft reset or another, cuts a download short
                        cmd_q <= req.wdata;
                        busy  <= 1'b1;
                        xreq  <= 1'b0;
                        state <= PQRM_ST_EXEC;
                    end else if (word_take) begin
                        word_cnt <= word_cnt + 8'h01;
                        if (last_word) begin
                            sect_left <= sect_left - 16'h0001;
                            if (last_sect) begin
                                // RULE_04 Good completion flags
                                // RULE_06 Rejected image ends in error
                                xreq    <= 1'b0;
                                dl_done <= 1'b1;
                                state   <= PQRM_ST_IDLE;
                                err_f   <= cfg[PQRM_CFG_REJ];
                                flt     <= cfg[PQRM_CFG_REJ] & cfg[PQRM_CFG_FLT];
                                fault   <= cfg[PQRM_CFG_REJ] ?
                                           (8'h01 << PQRM_BIT_ABORTED_FLAG) : PQRM_ZERO8;
                            end
                        end
                    end
                end
                default: state <= PQRM_ST_IDLE;
            endcase
        end
    end

    // Download steps
    sequence s_dl_end;
        word_take && last_word && last_sect && !take_cmd;
    endsequence
    sequence s_dl_open;
        state == PQRM_ST_EXEC && cmd_q == PQRM_CMD_FWDL && !take_cmd && !pkt
        && cfg[PQRM_CFG_FWDL] && sub_ok && rdy && dl_count != 16'h0000;
    endsequence

    // RULE_04 Completion leaves ready set and request clear
    AST_DONE_FLAGS: assert property (@(posedge core_clk) disable iff (srst) // RULE_04
        (state == PQRM_ST_EXEC && cmd_q == PQRM_CMD_PWRQ && pm_ok && rdy && !take_cmd)
        |=> (!busy && rdy && !xreq && !err_f && !flt))
        else $error("good completion flags wrong");
    // RULE_05 Abort bit on missing power management
    AST_PWRQ_ABORTED_FLAG: assert property (@(posedge core_clk) disable iff (srst) // RULE_05
        (state == PQRM_ST_EXEC && cmd_q == PQRM_CMD_PWRQ && !pm_ok)
        |=> (fault[PQRM_BIT_ABORTED_FLAG] && err_f))
        else $error("power query not aborted");
    // RULE_03 Result code
    AST_PWRQ_CODE: assert property (@(posedge core_clk) disable iff (srst) // RULE_03
        (state == PQRM_ST_EXEC && cmd_q == PQRM_CMD_PWRQ && pm_ok && rdy)
        |=> cnt_l == $past(pm_code))
        else $error("power result code wrong");
    // RULE_02 No data phase for the query
    AST_PWRQ_NODATA: assert property (@(posedge core_clk) disable iff (srst) // RULE_02
        (state == PQRM_ST_EXEC && cmd_q == PQRM_CMD_PWRQ)
        |=> (state != PQRM_ST_DATA && !xreq)[*2])
        else $error("query entered data phase");
    // RULE_10 Diagnostic code after reset
    AST_SRST_DIAG: assert property (@(posedge core_clk) disable iff (srst) // RULE_10
        (state == PQRM_ST_EXEC && cmd_q == PQRM_CMD_SRST && pkt)
        |=> (fault == $past(diag) && !err_f && unit[3:0] == 4'h0))
        else $error("soft reset outputs wrong");
    // RULE_10 Signature in count and address registers
    AST_SRST_SIG: assert property (@(posedge core_clk) disable iff (srst) // RULE_10
        (state == PQRM_ST_EXEC && cmd_q == PQRM_CMD_SRST && pkt)
        |=> (cnt_l == SIG_CNT && cnt_h == SIG_SEC && cyl_l == SIG_CYL && cyl_h == SIG_CYH))
        else $error("signature wrong");
    // RULE_11 Unsupported reset aborts
    AST_SRST_UNSUP: assert property (@(posedge core_clk) disable iff (srst) // RULE_11
        (state == PQRM_ST_EXEC && cmd_q == PQRM_CMD_SRST && !pkt && !take_cmd)
        |=> (fault[PQRM_BIT_ABORTED_FLAG] && err_f && !busy && rdy))
        else $error("reset not aborted");
    // RULE_09 Reset taken in every state, busy included
    AST_SRST_TAKE: assert property (@(posedge core_clk) disable iff (srst) // RULE_09
        (wr_cmd && is_srst)
        |=> state == PQRM_ST_EXEC)
        else $error("soft reset refused");
    // RULE_18 Bad subcommand aborts
    AST_FWDL_SUB: assert property (@(posedge core_clk) disable iff (srst) // RULE_18
        (state == PQRM_ST_EXEC && cmd_q == PQRM_CMD_FWDL && !sub_ok && !take_cmd)
        |=> (fault[PQRM_BIT_ABORTED_FLAG] && state == PQRM_ST_IDLE))
        else $error("bad subcommand accepted");
    // RULE_16 Zero count skips data phase
    AST_FWDL_ZERO: assert property (@(posedge core_clk) disable iff (srst) // RULE_16
        (state == PQRM_ST_EXEC && cmd_q == PQRM_CMD_FWDL && sub_ok && !pkt
         && cfg[PQRM_CFG_FWDL] && rdy && dl_count == 16'h0000 && !take_cmd)
        |=> (state == PQRM_ST_IDLE && !xreq))
        else $error("zero download moved data");
    // RULE_13 Accepted download opens data-out phase
    AST_FWDL_OPEN: assert property (@(posedge core_clk) disable iff (srst) // RULE_13
        s_dl_open
        |=> (state == PQRM_ST_DATA && xreq && dl_ready && sect_left == $past(dl_count)))
        else $error("data phase not opened");
    // RULE_16 One sector off per full sector of words
    AST_SECT_STEP: assert property (@(posedge core_clk) disable iff (srst) // RULE_16
        (word_take && last_word && !last_sect && !take_cmd)
        |=> (state == PQRM_ST_DATA && sect_left == $past(sect_left) - 16'h0001))
        else $error("sector step wrong");
    // RULE_04 Accepted image completes cleanly
    AST_DL_GOOD: assert property (@(posedge core_clk) disable iff (srst) // RULE_04
        (s_dl_end ##0 !cfg[PQRM_CFG_REJ])
        |=> (!busy && rdy && !xreq && !err_f && !flt && dl_done && !dl_ready))
        else $error("download completion wrong");
    // RULE_18 Rejected image ends aborted
    AST_DL_REJ: assert property (@(posedge core_clk) disable iff (srst) // RULE_18
        (s_dl_end ##0 cfg[PQRM_CFG_REJ])
        |=> (fault[PQRM_BIT_ABORTED_FLAG] && err_f && !xreq && dl_done))
        else $error("rejected image not aborted");
    // RULE_20 Completion keeps only the select bit
    AST_UNIT_SEL: assert property (@(posedge core_clk) disable iff (srst) // RULE_20
        state == PQRM_ST_EXEC
        |=> ((unit & ~(8'h01 << PQRM_BIT_SEL)) == PQRM_ZERO8
             && unit[PQRM_BIT_SEL] == $past(unit[PQRM_BIT_SEL])))
        else $error("unit register wrong");
    // RULE_06 Unknown command ends with error and ready set, busy clear
    AST_ERR_MATCH: assert property (@(posedge core_clk) disable iff (srst) // RULE_06
        (state == PQRM_ST_EXEC && cmd_q != PQRM_CMD_SRST && cmd_q != PQRM_CMD_FWDL
         && cmd_q != PQRM_CMD_PWRQ && !take_cmd) |=> (err_f && rdy && !busy && !xreq))
        else $error("error completion flags wrong");
endmodule
`default_nettype wire

/* bench/pqrm_host_model.sv */
// Host-side word source for the download data phase
`timescale 1ns/1ps
`default_nettype none
module pqrm_host_model (
    // Clock and reset
    input  wire logic           core_clk,
    input  wire logic           srst,
    // Control from the bench
    input  wire logic           go,
    input  wire logic           slow,
    // Data-out stream
    input  wire logic           dl_ready,
    output pqrm_pkg::pqrm_word_t dl_word,
    output logic [15:0]         words_sent
);
    import pqrm_pkg::*;

    always @(posedge core_clk) begin
        if (srst || !go) begin
            dl_word.valid <= 1'b0;
            dl_word.data  <= srst ? 16'h0F0F : ~dl_word.data;
            words_sent    <= 16'h0000;
        end else begin
            if (dl_word.valid && dl_ready) begin
                words_sent <= words_sent + 16'h0001;
            end
            // A word stays put until taken; slow mode stalls every other cycle
            if (!dl_word.valid || dl_ready) begin
                dl_word.valid <= slow ? !dl_word.valid : 1'b1;
                dl_word.data  <= dl_word.data + 16'h1357;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pqrm_pkg::*;
    // Signature bytes: arbitrary values
    localparam logic [7:0] SIG_A = 8'h3C;
    localparam logic [7:0] SIG_B = 8'hC3;
    localparam logic [7:0] SIG_C = 8'h14;
    localparam logic [7:0] SIG_D = 8'hEB;
    localparam logic [7:0] C_PM  = 8'h01 << PQRM_CFG_PM;
    localparam logic [7:0] C_PKT = 8'h01 << PQRM_CFG_PKT;
    localparam logic [7:0] C_DL  = 8'h01 << PQRM_CFG_FWDL;
    localparam logic [7:0] C_FT  = 8'h01 << PQRM_CFG_FT;
    localparam logic [7:0] C_FS  = 8'h01 << PQRM_CFG_FS;
    localparam logic [7:0] C_REJ = 8'h01 << PQRM_CFG_REJ;
    localparam logic [7:0] C_D1F = 8'h01 << PQRM_CFG_D1F;
    localparam logic [7:0] C_FLT = 8'h01 << PQRM_CFG_FLT;
    localparam logic [7:0] RDY   = 8'h01 << PQRM_BIT_RDY;
    localparam logic [7:0] ERR   = 8'h01 << PQRM_BIT_ERR;
    localparam logic [7:0] FLT   = 8'h01 << PQRM_BIT_FLT;
    localparam logic [7:0] XRQ   = 8'h01 << PQRM_BIT_XREQ;
    localparam logic [7:0] ABT   = 8'h01 << PQRM_BIT_ABORTED_FLAG;
    localparam logic [7:0] SEL   = 8'h01 << PQRM_BIT_SEL;

    logic        core_clk = 1'b0;
    logic        srst;
    pqrm_req_t   req;
    logic [7:0]  rdata;
    pqrm_word_t  dl_word;
    logic        dl_ready;
    pqrm_pm_t    pm_mode;
    logic        dl_done;
    logic [7:0]  dl_sub;
    logic        go;
    logic        slow;
    logic [15:0] words_sent;
    int          num_errors = 0;
    int          samples_checked = 0;

    always #2 core_clk = ~core_clk;

    pqrm_cmd #(.SIG_CNT(SIG_A), .SIG_SEC(SIG_B), .SIG_CYL(SIG_C), .SIG_CYH(SIG_D)) i_dut (
        .core_clk(core_clk), .srst(srst), .req(req), .rdata(rdata), .dl_word(dl_word),
        .dl_ready(dl_ready), .pm_mode(pm_mode), .dl_done(dl_done), .dl_sub(dl_sub));

    pqrm_host_model i_host (.core_clk(core_clk), .srst(srst), .go(go), .slow(slow),
        .dl_ready(dl_ready), .dl_word(dl_word), .words_sent(words_sent));

    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req <= '0;
        #1;
        chk({8'h00, rdata & m}, {8'h00, exp});
    endtask

    task automatic cmd(input logic [7:0] c);
        wr(PQRM_REG_CMD, c);
        repeat (2) @(posedge core_clk);
    endtask

    task automatic t_pwrq();
        logic [7:0] res [3] = '{PQRM_PM_STBY, PQRM_PM_IDLE, PQRM_PM_ACTV};
        wr(PQRM_REG_CFG, C_PM);
        for (int m = 0; m < 3; m++) begin
            @(posedge core_clk);
            pm_mode <= pqrm_pm_t'(m);
            wr(PQRM_REG_UNIT, 8'h1F);
            cmd(PQRM_CMD_PWRQ);
            #1;
            chk({15'h0000, dl_ready}, 16'h0000);
            rd(PQRM_REG_CNTL, res[m]);
            rd(PQRM_REG_FLAGS, RDY);
            rd(PQRM_REG_UNIT, SEL);
        end
    endtask

    task automatic t_abort(input logic [7:0] c, input logic [7:0] cf, input logic [7:0] fl);
        wr(PQRM_REG_CFG, cf);
        cmd(c);
        rd(PQRM_REG_FAULT, ABT);
        rd(PQRM_REG_FLAGS, fl);
    endtask

    task automatic t_srst(input logic [7:0] cf, input logic [7:0] diag);
        wr(PQRM_REG_CFG, cf);
        wr(PQRM_REG_CNTL, 8'hAA);
        wr(PQRM_REG_UNIT, 8'hFF);
        cmd(PQRM_CMD_SRST);
        rd(PQRM_REG_FAULT, diag);
        rd(PQRM_REG_CNTL, SIG_A);
        rd(PQRM_REG_CNTH, SIG_B);
        rd(PQRM_REG_CYLL, SIG_C);
        rd(PQRM_REG_CYLH, SIG_D);
        rd(PQRM_REG_UNIT, SEL);
        rd(PQRM_REG_FLAGS, RDY);
    endtask

    task automatic t_dl(input logic [7:0] cf, input logic [7:0] sub, input logic [7:0] nl,
                        input logic [7:0] nh, input logic [15:0] words, input logic [7:0] fl,
                        input logic sl);
        logic seen = 1'b0;
        wr(PQRM_REG_CFG, cf);
        wr(PQRM_REG_CYLL, 8'h00);
        wr(PQRM_REG_CYLH, 8'h00);
        wr(PQRM_REG_UNIT, SEL);
        wr(PQRM_REG_FEAT, sub);
        wr(PQRM_REG_CNTL, nl);
        wr(PQRM_REG_CNTH, nh);
        slow <= sl;
        go <= 1'b1;
        cmd(PQRM_CMD_FWDL);
        for (int i = 0; i < 4000 && words != 16'h0000; i++) begin
            @(posedge core_clk);
            #1;
            seen = dl_done === 1'b1;
            if (seen) break;
        end
        // Give a wrongly opened data phase time to take words
        if (words == 16'h0000) repeat (4) @(posedge core_clk);
        chk(words_sent, words);
        chk({8'h00, dl_sub}, {8'h00, sub});
        chk({15'h0000, seen}, {15'h0000, words != 16'h0000});
        @(posedge core_clk);
        go <= 1'b0;
        rd(PQRM_REG_FLAGS, fl);
    endtask

    // Soft reset written while the previous command is still busy
    task automatic t_busy();
        wr(PQRM_REG_CFG, C_PKT | C_PM);
        @(posedge core_clk);
        req <= '{addr: PQRM_REG_CMD, wdata: PQRM_CMD_PWRQ, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wdata <= PQRM_CMD_SRST;
        @(posedge core_clk);
        req <= '0;
        repeat (2) @(posedge core_clk);
        rd(PQRM_REG_CNTL, SIG_A);
        rd(PQRM_REG_FAULT, PQRM_DIAG_PASS);
    endtask

    // Soft reset lands in the middle of a long download
    task automatic t_mid();
        wr(PQRM_REG_CFG, C_DL | C_FT);
        wr(PQRM_REG_FEAT, PQRM_SUB_TEMP);
        wr(PQRM_REG_CNTL, 8'h00);
        wr(PQRM_REG_CNTH, 8'h01);
        go <= 1'b1;
        cmd(PQRM_CMD_FWDL);
        repeat (300) @(posedge core_clk);
        #1;
        chk({15'h0000, dl_ready}, 16'h0001);
        rd(PQRM_REG_FLAGS, XRQ, XRQ);
        rd(PQRM_REG_XFER, 8'hFF);
        wr(PQRM_REG_CFG, C_PKT | C_DL | C_FT);
        cmd(PQRM_CMD_SRST);
        go <= 1'b0;
        rd(PQRM_REG_FAULT, PQRM_DIAG_PASS);
        rd(PQRM_REG_FLAGS, RDY);
    endtask

    initial begin
        req = '0;
        pm_mode = PQRM_PM_MODE_ACTIVE;
        go = 1'b0;
        slow = 1'b0;
        srst = 1'b1;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        rd(PQRM_REG_FLAGS, RDY);
        t_pwrq();
        t_abort(PQRM_CMD_PWRQ, 8'h00, RDY | ERR);
        t_abort(PQRM_CMD_PWRQ, C_FLT, RDY | FLT | ERR);
        t_abort(8'hC3, C_PM, RDY | ERR);
        t_abort(PQRM_CMD_SRST, C_PM, RDY | ERR);
        t_srst(C_PKT, PQRM_DIAG_PASS);
        t_srst(C_PKT | C_D1F, PQRM_DIAG_D1F);
        t_dl(C_DL | C_FT | C_FS, PQRM_SUB_TEMP, 8'h02, 8'h00, 16'h0200, RDY, 1'b1);
        t_dl(C_DL | C_FS, PQRM_SUB_SAVE, 8'h01, 8'h00, 16'h0100, RDY, 1'b0);
        t_dl(C_DL | C_FT, PQRM_SUB_SAVE, 8'h01, 8'h00, 16'h0000, RDY | ERR, 1'b0);
        t_dl(C_DL | C_FT | C_FS, 8'h03, 8'h01, 8'h00, 16'h0000, RDY | ERR, 1'b0);
        t_dl(C_DL | C_FT, PQRM_SUB_TEMP, 8'h00, 8'h00, 16'h0000, RDY, 1'b0);
        t_dl(C_DL | C_FT | C_REJ, PQRM_SUB_TEMP, 8'h01, 8'h00, 16'h0100, RDY | ERR, 1'b0);
        t_dl(C_DL | C_FT | C_PKT, PQRM_SUB_TEMP, 8'h01, 8'h00, 16'h0000, RDY | ERR, 1'b0);
        t_dl(C_FT, PQRM_SUB_TEMP, 8'h01, 8'h00, 16'h0000, RDY | ERR, 1'b0);
        t_mid();
        t_busy();
        end_of_test();
    end

    // Watchdog: the whole sequence needs well under 50000 cycles
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
